// ==== logic/vgt_map.svh ====
// Register offsets, field positions, reset values and line counts for the vertical gate block
`ifndef VGT_MAP_SVH
`define VGT_MAP_SVH

`define VGT_OFS_START_LO   8'h15
`define VGT_OFS_STOP_LO    8'h16
`define VGT_OFS_MISC       8'h17
`define VGT_OFS_GAIN       8'h18

`define VGT_MISC_START_MSB 0
`define VGT_MISC_STOP_MSB  1
`define VGT_MISC_ALT_POS   2
`define VGT_MISC_HALF_DIS  6
`define VGT_MISC_LINE_DIS  7
`define VGT_MISC_RD_MASK   8'hC7

`define VGT_RST_START_LO   8'h00
`define VGT_RST_STOP_LO    8'h00
`define VGT_RST_MISC       8'h00
`define VGT_RST_GAIN       8'h80

`define VGT_INIT_50HZ      9'h138
`define VGT_INIT_60HZ      9'h106
`define VGT_GAIN_SHIFT     7
`define VGT_SAMPLE_MAX     8'hFF

`endif

// ==== logic/vgt_pkg.sv ====
// Types shared by the vertical gate block
`default_nettype none
package vgt_pkg;

   typedef struct packed {
      logic [7:0] start_lo;
      logic [7:0] stop_lo;
      logic [7:0] misc;
      logic [7:0] gain;
      logic [8:0] line_cnt;
      logic       gate;
      logic       field_ident;
      logic [7:0] rdata;
      logic       ack;
      logic [7:0] raw;
      logic       raw_vld;
   } vgt_state_t;

   typedef struct packed {
      logic       line_start;
      logic       field_start;
      logic       field2;
      logic       field_60hz;
   } vgt_timing_t;

endpackage : vgt_pkg
`default_nettype wire

// ==== logic/vgt_vertical_gate_timing.sv ====
// Vertical gate, field ident, line clock enables and raw sample gain
`timescale 1ns/100ps
`default_nettype none
`include "vgt_map.svh"

module vgt_vertical_gate_timing (
   input  wire logic       I_SYS_CLK,
   input  wire logic       I_NRST,
   input  wire logic       I_REG_WR,
   input  wire logic       I_REG_RD,
   input  wire logic [7:0] I_REG_ADDR,
   input  wire logic [7:0] I_REG_WDATA,
   output logic      [7:0] O_REG_RDATA,
   output logic            O_REG_ACK,
   input  wire logic       I_LINE_START,
   input  wire logic       I_FIELD_START,
   input  wire logic       I_FIELD2,
   input  wire logic       I_FIELD_60HZ,
   output logic            O_VERTICAL_GATE,
   output logic            O_FIELD_IDENT,
   output logic            O_LINE_CLOCK_OE,
   output logic            O_HALF_LINE_CLOCK_OE,
   input  wire logic       I_RAW_VALID,
   input  wire logic [7:0] I_RAW_DATA,
   output logic            O_RAW_VALID,
   output logic      [7:0] O_RAW_DATA
);

   vgt_pkg::vgt_state_t  st_r;
   vgt_pkg::vgt_state_t  st_nxt;
   vgt_pkg::vgt_timing_t tim;

   logic [8:0]  init_val;
   logic [8:0]  cnt_new;
   logic [8:0]  cmp_val;
   logic [8:0]  start_line;
   logic [8:0]  stop_line;
   logic [15:0] product;
   logic [8:0]  scaled;

   // Value that follows c on the next line of the field
   function automatic logic [8:0] next_val(input logic [8:0] c, input logic [8:0] init);
      next_val = (c == init) ? 9'h000 : 9'(c + 9'h001);
   endfunction : next_val

   // Bundle of line timing strobes from the sync logic
   assign tim = '{I_LINE_START, I_FIELD_START, I_FIELD2, I_FIELD_60HZ};

   // Programmed lines and first-line value of the field
   assign start_line = {st_r.misc[`VGT_MISC_START_MSB], st_r.start_lo};
   assign stop_line  = {st_r.misc[`VGT_MISC_STOP_MSB], st_r.stop_lo};
   assign init_val   = tim.field_60hz ? `VGT_INIT_60HZ : `VGT_INIT_50HZ;

   // Counter value of the line now starting
   assign cnt_new = tim.field_start ? init_val : next_val(st_r.line_cnt, init_val);

   // Field two looks one line ahead when the alternative position is set
   assign cmp_val = (tim.field2 && st_r.misc[`VGT_MISC_ALT_POS]) ?
                    next_val(cnt_new, init_val) : cnt_new;

   // Gain product, nominal at 128, saturated to eight bits
   assign product = 16'(I_RAW_DATA) * 16'(st_r.gain);
   assign scaled  = 9'(product >> `VGT_GAIN_SHIFT);

   // Next state
   always_comb begin
      st_nxt     = st_r;
      st_nxt.ack = 1'b0;
      // Register writes; unmapped offsets ignored
      if (I_REG_WR) begin
         case (I_REG_ADDR)
            `VGT_OFS_START_LO: st_nxt.start_lo = I_REG_WDATA;
            `VGT_OFS_STOP_LO:  st_nxt.stop_lo  = I_REG_WDATA;
            `VGT_OFS_MISC:     st_nxt.misc     = I_REG_WDATA;
            `VGT_OFS_GAIN:     st_nxt.gain     = I_REG_WDATA;
            default: begin
            end
         endcase
      end
      // Register reads; reserved misc bits and unmapped offsets read zero
      if (I_REG_RD) begin
         st_nxt.ack = 1'b1;
         case (I_REG_ADDR)
            `VGT_OFS_START_LO: st_nxt.rdata = st_r.start_lo;
            `VGT_OFS_STOP_LO:  st_nxt.rdata = st_r.stop_lo;
            `VGT_OFS_MISC:     st_nxt.rdata = st_r.misc & `VGT_MISC_RD_MASK;
            `VGT_OFS_GAIN:     st_nxt.rdata = st_r.gain;
            default:           st_nxt.rdata = 8'h00;
         endcase
      end
      // Line counting and gate edges; stop wins when both match
      if (tim.line_start) begin
         st_nxt.line_cnt = cnt_new;
         if (cmp_val == start_line) begin
            st_nxt.gate        = 1'b1;
            st_nxt.field_ident = tim.field2;
         end
         if (cmp_val == stop_line) begin
            st_nxt.gate = 1'b0;
         end
      end
      // Raw sample scaling
      st_nxt.raw_vld = I_RAW_VALID;
      if (I_RAW_VALID) begin
         st_nxt.raw = scaled[8] ? `VGT_SAMPLE_MAX : scaled[7:0];
      end
   end

   // State register
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         st_r             <= '0;
         st_r.start_lo    <= `VGT_RST_START_LO;
         st_r.stop_lo     <= `VGT_RST_STOP_LO;
         st_r.misc        <= `VGT_RST_MISC;
         st_r.gain        <= `VGT_RST_GAIN;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from state
   assign O_REG_RDATA          = st_r.rdata;
   assign O_REG_ACK            = st_r.ack;
   assign O_VERTICAL_GATE      = st_r.gate;
   assign O_FIELD_IDENT        = st_r.field_ident;
   assign O_LINE_CLOCK_OE      = ~st_r.misc[`VGT_MISC_LINE_DIS];
   assign O_HALF_LINE_CLOCK_OE = ~st_r.misc[`VGT_MISC_HALF_DIS];
   assign O_RAW_VALID          = st_r.raw_vld;
   assign O_RAW_DATA           = st_r.raw;

   // Checks
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_NRST);

   property p_gate_rise;
      $rose(O_VERTICAL_GATE) |-> $past(I_LINE_START) && ($past(cmp_val) == $past(start_line));
   endproperty
   a_gate_rise: assert property (p_gate_rise) else $error("gate rose off the start line");

   property p_gate_fall;
      $fell(O_VERTICAL_GATE) |-> $past(I_LINE_START) && ($past(cmp_val) == $past(stop_line));
   endproperty
   a_gate_fall: assert property (p_gate_fall) else $error("gate fell off the stop line");

   property p_gate_hold;
      !I_LINE_START |=> $stable(O_VERTICAL_GATE) && $stable(O_FIELD_IDENT);
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("gate moved between lines");

   property p_init_50;
      I_FIELD_START && I_LINE_START && !I_FIELD_60HZ |=> st_r.line_cnt == 9'h138;
   endproperty
   a_init_50: assert property (p_init_50) else $error("50 Hz field not at 312");

   property p_init_60;
      I_FIELD_START && I_LINE_START && I_FIELD_60HZ |=> st_r.line_cnt == 9'h106;
   endproperty
   a_init_60: assert property (p_init_60) else $error("60 Hz field not at 262");

   property p_wrap;
      I_LINE_START && !I_FIELD_START && st_r.line_cnt == init_val |=> st_r.line_cnt == 9'h000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("count did not wrap to zero");

   property p_alt;
      I_LINE_START && I_FIELD2 && st_r.misc[2] && next_val(cnt_new, init_val) == start_line
         && cnt_new != stop_line && next_val(cnt_new, init_val) != stop_line |=> O_VERTICAL_GATE;
   endproperty
   a_alt: assert property (p_alt) else $error("early gate missing in field two");

   property p_clk_oe;
      I_REG_WR && I_REG_ADDR == 8'h17 |=> O_LINE_CLOCK_OE == !$past(I_REG_WDATA[7])
         && O_HALF_LINE_CLOCK_OE == !$past(I_REG_WDATA[6]);
   endproperty
   a_clk_oe: assert property (p_clk_oe) else $error("clock output enable wrong");

   property p_gain_off;
      I_RAW_VALID && st_r.gain == 8'h00 |=> O_RAW_VALID && O_RAW_DATA == 8'h00;
   endproperty
   a_gain_off: assert property (p_gain_off) else $error("gain zero not off");

   property p_gain_nom;
      I_RAW_VALID && st_r.gain == 8'h80 |=> O_RAW_DATA == $past(I_RAW_DATA);
   endproperty
   a_gain_nom: assert property (p_gain_nom) else $error("nominal gain altered data");

   property p_raw_vld;
      O_RAW_VALID == $past(I_RAW_VALID);
   endproperty
   a_raw_vld: assert property (p_raw_vld) else $error("raw valid not one cycle late");

   property p_cov_wrap_gate;
      I_FIELD_START && I_LINE_START && O_VERTICAL_GATE ##1 O_VERTICAL_GATE;
   endproperty
   c_cov_wrap_gate: cover property (p_cov_wrap_gate);

   property p_cov_alt_rise;
      I_FIELD2 && st_r.misc[2] ##1 $rose(O_VERTICAL_GATE);
   endproperty
   c_cov_alt_rise: cover property (p_cov_alt_rise);

   property p_cov_sat;
      I_RAW_VALID && scaled[8];
   endproperty
   c_cov_sat: cover property (p_cov_sat);

   property p_cov_60_wrap;
      I_FIELD_60HZ && I_FIELD_START && I_LINE_START && O_VERTICAL_GATE ##1 !O_VERTICAL_GATE;
   endproperty
   c_cov_60_wrap: cover property (p_cov_60_wrap);

endmodule : vgt_vertical_gate_timing

`default_nettype wire

// ==== testbench/vgt_sync_src.sv ====
// Line and field timing source feeding the gate block
`timescale 1ns/100ps
`default_nettype none
module vgt_sync_src (
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_hz60,
   output logic            o_line_start,
   output logic            o_field_start,
   output logic            o_field2,
   output logic      [8:0] o_line_idx
);
   logic [1:0] cyc_r;
   // Four clocks a line; first field one line longer than second
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cyc_r <= 2'h0;
         o_line_start <= 1'b0;
         o_field_start <= 1'b0;
         o_field2 <= 1'b1;
         o_line_idx <= 9'h1FF;
      end else begin
         cyc_r <= cyc_r + 2'h1;
         o_line_start <= (cyc_r == 2'h3);
         o_field_start <= 1'b0;
         if (cyc_r == 2'h3) begin
            if (o_line_idx >= (i_hz60 ? 9'h106 : 9'h138) - {8'h00, o_field2}) begin
               o_line_idx <= 9'h000;
               o_field_start <= 1'b1;
               o_field2 <= ~o_field2;
            end else begin
               o_line_idx <= o_line_idx + 9'h001;
            end
         end
      end
   end
endmodule : vgt_sync_src
`default_nettype wire

// ==== testbench/vgt_vertical_gate_timing_tb.sv ====
// Self-checking bench for the vertical gate block
`timescale 1ns/100ps
`default_nettype none
`include "vgt_map.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
   $display("Error %0t: got %h expected %h", $time, a, b); end end
module vgt_vertical_gate_timing_tb;
   logic       clk, nrst, wr, rd, ack, ls, fs, f2, hz60, gate, ident, loe, hoe;
   logic       rv, orv;
   logic [7:0] addr, wdata, rdata, rdd, ord;
   logic [8:0] idx;
   int         error_cnt = 0;
   int         checked = 0;
   // Clock of 25 ns
   always #12.5 clk = ~clk;
   vgt_vertical_gate_timing vgt_vertical_gate_timing_i (.I_SYS_CLK(clk), .I_NRST(nrst),
      .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
      .O_REG_RDATA(rdata), .O_REG_ACK(ack), .I_LINE_START(ls), .I_FIELD_START(fs),
      .I_FIELD2(f2), .I_FIELD_60HZ(hz60), .O_VERTICAL_GATE(gate), .O_FIELD_IDENT(ident),
      .O_LINE_CLOCK_OE(loe), .O_HALF_LINE_CLOCK_OE(hoe), .I_RAW_VALID(rv),
      .I_RAW_DATA(rdd), .O_RAW_VALID(orv), .O_RAW_DATA(ord));
   vgt_sync_src vgt_sync_src_i (.i_clk(clk), .i_nrst(nrst), .i_hz60(hz60),
      .o_line_start(ls), .o_field_start(fs), .o_field2(f2), .o_line_idx(idx));
   task automatic end_of_test;
      $display("Summary: %0d errors in %0d checks", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk); wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge clk); wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk); rd <= 1'b1; addr <= a;
      @(posedge clk); rd <= 1'b0; #1;
      `CHK(ack, 1'b1)
      `CHK(rdata, e)
   endtask : rd_chk
   // Reset values of outputs and registers
   task automatic t_reset;
      `CHK({loe, hoe}, 2'h3)
      rd_chk(`VGT_OFS_GAIN, `VGT_RST_GAIN);
      rd_chk(8'h19, 8'h00);
   endtask : t_reset
   task automatic t_oe(input logic [7:0] v);
      wr_reg(`VGT_OFS_MISC, v); #1;
      `CHK({loe, hoe}, ~v[7:6])
      rd_chk(`VGT_OFS_MISC, v & `VGT_MISC_RD_MASK);
   endtask : t_oe
   task automatic t_raw(input logic [7:0] g, input logic [7:0] d, input logic [7:0] e);
      wr_reg(`VGT_OFS_GAIN, g);
      @(posedge clk); rv <= 1'b1; rdd <= d;
      @(posedge clk); rv <= 1'b0; #1;
      `CHK({orv, ord}, {1'b1, e})
      @(posedge clk);
      #1;
      `CHK({orv, ord}, {1'b0, e})
   endtask : t_raw
   // Waits for a gate edge in the wanted field, then checks the line
   task automatic gate_edge(input logic v, input logic [1:0] f, input logic [8:0] e);
      int n; logic p, hit;
      n = 0; hit = 1'b0;
      while (!hit && n < 4000) begin
         p = gate; @(posedge clk); #1; n++;
         hit = (gate === v && p !== v && (f[1] || f2 === f[0]));
      end
      `CHK(hit, 1'b1)
      `CHK(idx, e)
      if (v) `CHK(ident, f2)
   endtask : gate_edge
   task automatic t_gate(input logic hz, input logic [7:0] m, input logic [7:0] s,
      input logic [7:0] p, input logic [1:0] rf, input logic [8:0] ri,
      input logic [1:0] ff, input logic [8:0] fi);
      int n;
      @(posedge clk); hz60 <= hz;
      wr_reg(`VGT_OFS_START_LO, s); wr_reg(`VGT_OFS_STOP_LO, p); wr_reg(`VGT_OFS_MISC, m);
      n = 0;
      while (fs !== 1'b1 && n < 1400) begin @(posedge clk); #1; n++; end
      `CHK(fs, 1'b1)
      gate_edge(1'b1, rf, ri);
      gate_edge(1'b0, ff, fi);
   endtask : t_gate
   // Main sequence
   initial begin
      clk = 0; nrst = 0; wr = 0; rd = 0; addr = 0; wdata = 0; hz60 = 0; rv = 0; rdd = 0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_oe(8'h80); t_oe(8'h40); t_oe(8'hC0); t_oe(8'h00);
      t_oe(8'hF8); t_oe(8'h00);
      t_raw(8'h80, 8'h64, 8'h64); t_raw(8'hFF, 8'h40, 8'h7F);
      t_raw(8'hFF, 8'hC8, 8'hFF); t_raw(8'h00, 8'hC8, 8'h00);
      t_gate(0, 8'h02, 8'h00, 8'h36, 2'b00, 9'd1, 2'b00, 9'd311);
      t_gate(0, 8'h01, 8'h38, 8'h00, 2'b01, 9'd0, 2'b01, 9'd1);
      t_gate(1, 8'h03, 8'h04, 8'h06, 2'b00, 9'd261, 2'b01, 9'd0);
      t_gate(0, 8'h04, 8'h00, 8'h05, 2'b01, 9'd0, 2'b01, 9'd5);
      t_gate(0, 8'h04, 8'h00, 8'h05, 2'b00, 9'd1, 2'b00, 9'd6);
      end_of_test();
   end
   // Watchdog against a hang
   initial begin
      #(25 * 60000);
      error_cnt++;
      end_of_test();
   end
endmodule : vgt_vertical_gate_timing_tb
`default_nettype wire
